// ==== inc/hwcfg_pkg.sv ====
// Constants and types for the configuration and attach control block
package hwcfg_pkg;

  // Register byte offsets (low address bits decoded)
  localparam int ADDR_W = 12;
  localparam logic [11:0] CONFIG_OFS = 12'h010;
  localparam logic [11:0] INT_STS_OFS = 12'h014;
  localparam logic [11:0] INT_MASK_OFS = 12'h018;

  // Field positions in the configuration register
  localparam int IND_LSB = 20;
  localparam int IND_W = 4;
  localparam int DET_STS_BIT = 15;
  localparam int DET_EN_BIT = 14;
  localparam int EMU_BIT = 13;
  localparam int PROT_BIT = 12;
  localparam int BUF_BIT = 10;
  localparam int CON_EN_BIT = 9;

  // Values after reset
  localparam logic [3:0] IND_RST = 4'h0;
  localparam logic EMU_RST = 1'b0;
  localparam logic PROT_RST = 1'b0;
  localparam logic BUF_RST = 1'b0;
  localparam logic CON_EN_RST = 1'b0;
  localparam logic DET_STS_RST = 1'b0;

  // Interrupt status and mask layout
  localparam int INT_W = 2;
  localparam int INT_REATTACH = 0;
  localparam int INT_DETACH = 1;
  localparam logic [1:0] INT_RST = 2'h0;

  // Attach state machine, one-hot
  typedef enum logic [2:0] {
    ST_ATTACHING = 3'b001,
    ST_DETACHED = 3'b010,
    ST_ATTACHED = 3'b100
  } link_state_t;

endpackage

// ==== inc/reg_bus_if.sv ====
// Internal register access carrier between bus port and register bank
interface reg_bus_if;
  import hwcfg_pkg::*;
  logic [ADDR_W-1:0] addr; // Byte address of the data phase
  logic wr; // Write strobe, one cycle
  logic [31:0] wdata; // Write data
  logic [31:0] rdata; // Read data from the bank
  modport port (output addr, output wr, output wdata, input rdata);
  modport regs (input addr, input wr, input wdata, output rdata);
endinterface

// ==== core/ahb_port.sv ====
// AHB-Lite slave front end feeding the register bank
module ahb_port
  import hwcfg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AHB-Lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register bank side
  reg_bus_if.port bus
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr; // Latched address
    logic wr; // Write data phase pending
    logic rd; // Read wait cycle pending
    logic [31:0] rdata; // Registered read data
  } port_state_t;

  port_state_t q, n;
  logic take; // Address phase accepted

  // Any NONSEQ or SEQ transfer; size is not checked, only words are used
  assign take = hsel & htrans[1] & hready;

  // Next state of the front end
  always_comb begin
    n = q;
    n.wr = 1'b0;
    n.rd = 1'b0;
    // Read sampled one cycle late so a preceding write is seen
    if (q.rd) begin
      n.rdata = bus.rdata;
    end
    if (take) begin
      n.addr = haddr[ADDR_W-1:0];
      n.wr = hwrite;
      n.rd = ~hwrite;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // One wait state on reads, none on writes
  assign hreadyout = ~q.rd;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign bus.addr = q.addr;
  assign bus.wr = q.wr;
  assign bus.wdata = hwdata;

endmodule // ahb_port

// ==== core/attach_pin.sv ====
// Output driver for the attach indicator pin
module attach_pin (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic assert_req,
  input wire logic push_pull,
  // Pin
  output logic pin_o,
  output logic pin_oe_n
);

  typedef struct packed {
    logic o; // Driven level
    logic oe_n; // Low while driving
  } pin_state_t;

  pin_state_t q, n;

  // Push-pull drives both levels; open drain only pulls low
  always_comb begin
    n = q;
    if (push_pull) begin
      n.o = assert_req;
      n.oe_n = 1'b0;
    end else begin
      // Asserted level comes from the external pull-up
      n.o = 1'b0;
      n.oe_n = assert_req;
    end
  end

  // Pin register; released at reset so nothing is forced
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{o: 1'b0, oe_n: 1'b1};
    end else begin
      q <= n;
    end
  end

  assign pin_o = q.o;
  assign pin_oe_n = q.oe_n;

endmodule // attach_pin

// ==== core/hardware_config_attach_control.sv ====
// Configuration register bank with detach and reattach control
//
// The AHB-Lite register port is this design's own decision.
module hardware_config_attach_control
  import hwcfg_pkg::*;
(
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rstn,
  // Synchronous reset from any source other than power-on
  input wire logic soft_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Configuration memory presence
  input wire logic eeprom_present,
  input wire logic otp_configured,
  // Reattach causes
  input wire logic phy_link_up,
  input wire logic gpio_wake,
  // USB core handshake
  input wire logic usb_configured,
  output logic usb_attach_req,
  // Descriptor source to the USB core
  output logic descr_from_ram,
  // Indicator pin enables
  output logic [3:0] indicator_enable,
  // Attach indicator pin
  output logic connect_o,
  output logic connect_oe_n,
  // Interrupt
  output logic irq
);

  // Bank in brief
  // One configuration word, one event status word, one mask word
  // Detach command takes the device off the bus until a cause
  // Link up or wake pin brings it back and marks the event
  // Event bits are sticky and cleared by writing ones
  // Interrupt line is a level, high while an unmasked bit is set
  // Every output registered, so decode glitches never reach pins
  // Power-on reset: asynchronous, restores every default
  // Other resets: synchronous, spare shielded fields under protect
  // Limitation: shielding covers only this word, not its neighbours

  // All register and sequencing state of the bank
  typedef struct packed {
    logic [IND_W-1:0] ind_en; // Indicator enables
    logic det_sts; // Detach event status
    logic det_cmd; // Self-clearing detach command
    logic emu_sel; // Descriptor source select
    logic protect; // Reset protection
    logic buf_pp; // Attach pin push-pull
    logic con_en; // Attach pin enable
    logic [INT_W-1:0] int_sts; // Sticky event bits
    logic [INT_W-1:0] int_mask; // Interrupt enables
    link_state_t st; // Attach sequencing state
    logic usb_req; // Registered attach request
    logic descr_ram; // Registered descriptor source
    logic [IND_W-1:0] ind_out; // Registered indicator enables
    logic irq; // Registered interrupt line
  } bank_state_t;

  bank_state_t q, n;

  reg_bus_if bus ();

  // Decoded register hits in the data phase
  logic hit_cfg;
  logic hit_sts;
  logic hit_mask;
  logic wr_cfg;
  logic wr_sts;
  logic wr_mask;
  logic reattach; // Reattach cause in the detached state
  logic sts_clr; // Software clears detach status
  logic [INT_W-1:0] int_set; // Events this cycle
  logic [INT_W-1:0] int_clr; // Write-one-clear bits
  logic pin_assert; // Attach indicator request

  // Read data leave the bank a cycle after the address
  // So a read right behind a write sees the new value
  // Writes complete with no wait state
  // Bus front end with one wait state on reads
  ahb_port u_port (
    .core_clk(core_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bus(bus.port)
  );

  // Only the low twelve address bits are compared
  // Upper bits alias, traded for a narrow comparator
  // Decode works on the latched data-phase address
  // Address decode; unmapped addresses read zero and ignore writes
  always_comb begin
    hit_cfg = 1'b0;
    hit_sts = 1'b0;
    hit_mask = 1'b0;
    if (bus.addr == CONFIG_OFS) begin
      hit_cfg = 1'b1;
    end else if (bus.addr == INT_STS_OFS) begin
      hit_sts = 1'b1;
    end else if (bus.addr == INT_MASK_OFS) begin
      hit_mask = 1'b1;
    end
  end

  assign wr_cfg = bus.wr & hit_cfg;
  assign wr_sts = bus.wr & hit_sts;
  assign wr_mask = bus.wr & hit_mask;

  // Causes count only while detached
  // A link already up while attached raises no event
  // Either cause ends a commanded detach
  assign reattach = (q.st == ST_DETACHED) & (phy_link_up | gpio_wake);

  // Clear and a same-cycle reattach: the reattach wins below
  // Status clear by writing a one to bit 15
  assign sts_clr = wr_cfg & bus.wdata[DET_STS_BIT];

  // Detach event marks the command cycle itself
  // Reattach event marks the cycle the cause is seen
  // Events feeding the interrupt status
  always_comb begin
    int_set = '0;
    int_set[INT_REATTACH] = reattach;
    int_set[INT_DETACH] = q.det_cmd;
  end

  assign int_clr = wr_sts ? bus.wdata[INT_W-1:0] : '0;

  // Command bit reads back only in its single live cycle
  // Status word and mask share one two-bit layout
  // Read multiplexer; reserved and unused bits stay zero
  always_comb begin
    bus.rdata = 32'h0000_0000;
    if (hit_cfg) begin
      bus.rdata[IND_LSB +: IND_W] = q.ind_en;
      bus.rdata[DET_STS_BIT] = q.det_sts;
      bus.rdata[DET_EN_BIT] = q.det_cmd;
      bus.rdata[EMU_BIT] = q.emu_sel;
      bus.rdata[PROT_BIT] = q.protect;
      bus.rdata[BUF_BIT] = q.buf_pp;
      bus.rdata[CON_EN_BIT] = q.con_en;
    end else if (hit_sts) begin
      bus.rdata[INT_W-1:0] = q.int_sts;
    end else if (hit_mask) begin
      bus.rdata[INT_W-1:0] = q.int_mask;
    end
  end

  // Next state of the register bank
  always_comb begin
    n = q;
    // Command bit lives for one cycle only
    n.det_cmd = 1'b0;

    // Whole word written at once, no byte strobes
    // Transfers of any size reach this bank; hsize is not checked
    // Configuration writes; reserved positions are never stored
    if (wr_cfg) begin
      n.ind_en = bus.wdata[IND_LSB +: IND_W];
      n.emu_sel = bus.wdata[EMU_BIT];
      n.protect = bus.wdata[PROT_BIT];
      n.buf_pp = bus.wdata[BUF_BIT];
      n.con_en = bus.wdata[CON_EN_BIT];
      n.det_cmd = bus.wdata[DET_EN_BIT];
    end

    // Mask register
    if (wr_mask) begin
      n.int_mask = bus.wdata[INT_W-1:0];
    end

    // Three states, no counters
    // Command override sits after the case, so it wins
    // Branches read only the core handshake and the causes
    // Attach sequencing
    case (q.st)
      ST_ATTACHING: begin
        // Enumeration done ends the attempt
        if (usb_configured) begin
          n.st = ST_ATTACHED;
        end
      end
      ST_ATTACHED: begin
        // Host lost the device: try again
        if (!usb_configured) begin
          n.st = ST_ATTACHING;
        end
      end
      ST_DETACHED: begin
        // Stays off the bus until a cause appears
        if (reattach) begin
          n.st = ST_ATTACHING;
        end
      end
      default: begin
        n.st = ST_ATTACHING;
      end
    endcase
    // Command wins over any other transition
    if (q.det_cmd) begin
      n.st = ST_DETACHED;
    end

    // Status survives soft reset so a reloaded driver can read it
    // Detach status: a set in the clearing cycle survives
    n.det_sts = (q.det_sts & ~sts_clr) | reattach;

    // Events are single pulses, so a lost set is lost for good
    // Set term applied last for that reason
    // Sticky event bits, set wins over clear
    n.int_sts = (q.int_sts & ~int_clr) | int_set;

    // Soft reset comes last, so it beats a same-cycle write
    // Protect is taken from the stored value
    // A write setting protect in the reset cycle shields nothing yet
    // Detach status and attach state are left alone on purpose
    // Non power-on reset overrides the command, event, mask and unshielded fields above
    if (soft_rst) begin
      n.det_cmd = 1'b0;
      n.int_sts = INT_RST;
      n.int_mask = INT_RST;
      // Shielded fields keep their values while protect is set
      if (!q.protect) begin
        n.ind_en = IND_RST;
        n.emu_sel = EMU_RST;
        n.protect = PROT_RST;
        n.buf_pp = BUF_RST;
        n.con_en = CON_EN_RST;
      end
    end

    // Outputs below are taken from the next state
    // So each one changes at the same edge as its source
    // Registered outputs
    n.usb_req = (n.st != ST_DETACHED);
    // Select only counts without external configuration
    n.descr_ram = n.emu_sel & ~eeprom_present & ~otp_configured;
    n.ind_out = n.ind_en;
    n.irq = |(n.int_sts & n.int_mask);
  end

  // Asynchronous reset branch assigns constants only
  // Bank register; power-on reset restores every default
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{
        ind_en: IND_RST,
        det_sts: DET_STS_RST,
        det_cmd: 1'b0,
        emu_sel: EMU_RST,
        protect: PROT_RST,
        buf_pp: BUF_RST,
        con_en: CON_EN_RST,
        int_sts: INT_RST,
        int_mask: INT_RST,
        st: ST_ATTACHING,
        usb_req: 1'b1,
        descr_ram: 1'b0,
        ind_out: IND_RST,
        irq: 1'b0
      };
    end else begin
      q <= n;
    end
  end

  // Pin asserts during every attach attempt, reattach included
  // Taken from the next state, like the attach request
  // So the pin never shows asserted while detached
  assign pin_assert = n.con_en & (n.st == ST_ATTACHING);

  // Buffer type also from the next state, to keep the pin in step
  // Attach indicator driver
  attach_pin u_pin (
    .core_clk(core_clk),
    .rstn(rstn),
    .assert_req(pin_assert),
    .push_pull(n.buf_pp),
    .pin_o(connect_o),
    .pin_oe_n(connect_oe_n)
  );

  // Outputs straight from the bank register
  assign usb_attach_req = q.usb_req;
  assign descr_from_ram = q.descr_ram;
  assign indicator_enable = q.ind_out;
  assign irq = q.irq;

endmodule // hardware_config_attach_control

// ==== test/hwcfg_monitor.sv ====
// Port checker for the configuration and attach control block
module hwcfg_monitor
  import hwcfg_pkg::*;
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic soft_rst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Device inputs
  input wire logic eeprom_present,
  input wire logic otp_configured,
  input wire logic phy_link_up,
  input wire logic gpio_wake,
  input wire logic usb_configured,
  // Device outputs
  input wire logic usb_attach_req,
  input wire logic descr_from_ram,
  input wire logic [3:0] indicator_enable,
  input wire logic connect_o,
  input wire logic connect_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  // Soft reset may rewrite fields, so checks pause across it
  default disable iff (!rstn || soft_rst);
  // Write taken to the configuration word
  sequence cfg_wr;
    hsel && htrans[1] && hready && hwrite && haddr[11:0] == CONFIG_OFS;
  endsequence
  // Same write carrying the detach command
  sequence det_wr;
    cfg_wr ##1 hwdata[DET_EN_BIT];
  endsequence
  a_ind_follow: assert property (cfg_wr |->
    ##3 indicator_enable == $past(hwdata[IND_LSB +: IND_W], 2))
    else $error("indicator enables do not follow write");
  a_descr_gate: assert property (descr_from_ram |->
    !$past(eeprom_present) && !$past(otp_configured))
    else $error("descriptor select active with memory present");
  a_detach_drop: assert property (det_wr |-> ##3 !usb_attach_req)
    else $error("no detach after command");
  a_cause_attach: assert property (
    !usb_attach_req && (phy_link_up || gpio_wake) |-> ##2 usb_attach_req)
    else $error("no reattach after cause");
  a_pin_drive: assert property (connect_o |-> !connect_oe_n)
    else $error("attach pin high while released");
  a_pin_attach: assert property (connect_o |-> usb_attach_req)
    else $error("attach pin asserted while detached");
  a_pin_drop: assert property (
    usb_configured [*2] |-> ##1 !connect_o)
    else $error("attach pin held after attach");
  a_rsvd_zero: assert property (hrdata[31:24] == 8'h00
    && hrdata[19:16] == 4'h0 && !hrdata[11])
    else $error("reserved bits read nonzero");
endmodule // hwcfg_monitor

bind hardware_config_attach_control hwcfg_monitor u_mon (
  .core_clk, .rstn, .soft_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .eeprom_present, .otp_configured, .phy_link_up,
  .gpio_wake, .usb_configured, .usb_attach_req, .descr_from_ram,
  .indicator_enable, .connect_o, .connect_oe_n);

// ==== test/usb_host_model.sv ====
// Model of the USB host that enumerates the device
module usb_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Device side
  input wire logic usb_attach_req,
  input wire logic [3:0] dly,
  output logic usb_configured
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q; // Cycles since attach
  // Enumerate some cycles after attach, forget the device at once on detach
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      usb_configured <= 1'b0;
    end else if (!usb_attach_req) begin
      cnt_q <= 4'h0;
      usb_configured <= 1'b0;
    end else if (cnt_q < dly) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      usb_configured <= 1'b1;
    end
  end
endmodule // usb_host_model

// ==== test/tb_top.sv ====
// Self-checking bench for configuration and attach control
module tb_top
  import hwcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rstn = 1'b0, soft_rst = 1'b0; // Clock, resets
  logic hsel = 1'b0, hwrite = 1'b0; // Bus controls
  logic [1:0] htrans = 2'h0; // Transfer type
  logic [2:0] hsize = 3'h2; // Word transfers only
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, v, hrdata; // Bus words
  logic eeprom_present = 1'b0, otp_configured = 1'b0; // Memory presence
  logic phy_link_up = 1'b0, gpio_wake = 1'b0; // Reattach causes
  logic [3:0] dly = 4'h8, indicator_enable; // Host delay, enables
  logic hreadyout, hresp, usb_configured, usb_attach_req; // Outputs
  logic descr_from_ram, connect_o, connect_oe_n, irq; // Outputs
  int fails = 0, checked = 0, n; // Counters
  hardware_config_attach_control u_dut (.core_clk, .rstn, .soft_rst,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .eeprom_present, .otp_configured,
    .phy_link_up, .gpio_wake, .usb_configured, .usb_attach_req,
    .descr_from_ram, .indicator_enable, .connect_o, .connect_oe_n, .irq);
  usb_host_model u_host (.core_clk, .rstn, .usb_attach_req, .dly,
    .usb_configured);
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  // Compare one value
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait for ready; a hang ends the run
  task wait_rdy;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      report_and_stop;
    end
  endtask
  // One single transfer; read data taken at the closing edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // Read and compare
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // Bounded wait for the attach request level
  task waitreq(input logic lvl);
    n = 0;
    while (usb_attach_req !== lvl && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 60) begin
      fails++;
      report_and_stop;
    end
  endtask
  // Readable part of a configuration write
  function logic [31:0] cfg_exp(input logic [31:0] w);
    return w & 32'h00F0_3600;
  endfunction
  // Main sequence
  initial begin
    void'($urandom(95));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdchk("cfg rst", CONFIG_OFS, 32'h0);
    bus(1'b1, 12'h020, 32'hFFFF_FFFF);
    rdchk("unmapped", 12'h020, 32'h0);
    chk("resp", 32'(hresp), 32'h0);
    $display("test reset done");
    // Random words, first one with reserved bits 31:24, 19:16 and 11 set
    for (int i = 0; i < 6; i++) begin
      v = $urandom() & 32'hFFFF_BFFF | (i == 0 ? 32'hFF0F_0800 : 32'h0);
      eeprom_present <= v[0];
      otp_configured <= v[1];
      bus(1'b1, CONFIG_OFS, v);
      rdchk("cfg", CONFIG_OFS, cfg_exp(v));
      chk("ind", 32'(indicator_enable), 32'(v[23:20]));
      chk("descr", 32'(descr_from_ram), 32'(v[13] & ~v[0] & ~v[1]));
    end
    $display("test random done");
    eeprom_present <= 1'b0;
    otp_configured <= 1'b0;
    // Soft reset with protect clear, then set
    for (int p = 0; p < 2; p++) begin
      v = p ? 32'h00F0_3600 : 32'h00A0_2600;
      bus(1'b1, CONFIG_OFS, v);
      soft_rst <= 1'b1;
      @(posedge core_clk);
      soft_rst <= 1'b0;
      rdchk("prot", CONFIG_OFS, p ? v : 32'h0);
    end
    chk("descr ram", 32'(descr_from_ram), 32'h1);
    rstn <= 1'b0;
    @(posedge core_clk);
    rstn <= 1'b1;
    rdchk("por", CONFIG_OFS, 32'h0);
    $display("test protect done");
    // Detach, then reattach by link or wake pin
    for (int i = 0; i < 2; i++) begin
      dly <= 4'($urandom_range(15, 2));
      v = i ? 32'h200 : 32'h600;
      bus(1'b1, INT_MASK_OFS, i ? 32'h0 : 32'h3);
      bus(1'b1, CONFIG_OFS, v | 32'h4000);
      rdchk("selfclr", CONFIG_OFS, v);
      waitreq(1'b0);
      chk("irq", 32'(irq), 32'(i == 0));
      rdchk("ists", INT_STS_OFS, i ? 32'h3 : 32'h2);
      bus(1'b1, INT_STS_OFS, 32'h3);
      rdchk("ists clr", INT_STS_OFS, 32'h0);
      if (i) gpio_wake <= 1'b1;
      else phy_link_up <= 1'b1;
      waitreq(1'b1);
      phy_link_up <= 1'b0;
      gpio_wake <= 1'b0;
      chk("pin on", {connect_o, connect_oe_n}, 2'h2 >> i);
      rdchk("sts", CONFIG_OFS, v | 32'h8000);
      bus(1'b1, CONFIG_OFS, v | 32'h8000);
      rdchk("sts clr", CONFIG_OFS, v);
      repeat (20) @(posedge core_clk);
      chk("pin off", {connect_o, connect_oe_n}, 2'b00);
      $display("test detach %0d done", i);
    end
    report_and_stop;
  end
endmodule // tb_top
